// ==== inc/olc_pkg.sv ====
package olc_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_FAIL_SRC  = 8'h3c;
   localparam logic [7:0] OFF_MAKER_ID  = 8'h40;
   localparam logic [7:0] OFF_CTRL_SET  = 8'h50;
   localparam logic [7:0] OFF_CTRL_CLR  = 8'h54;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_IMG_READY  = 31;
   localparam int BIT_SWAP_DIS   = 30;
   localparam int BIT_LATE_ACK   = 29;
   localparam int BIT_PHY_OWNER  = 23;
   localparam int BIT_LINK_ACT   = 17;
   localparam int BUS_NUM_LSB    = 22;
   localparam int NODE_NUM_LSB   = 16;
   // ------------------------------------------------------------
   // values after reset and fixed values
   // ------------------------------------------------------------
   localparam logic [31:0] MAKER_ID_VAL  = 32'h00c0_ffee; // arbitrary value
   localparam logic [31:0] FAIL_SRC_RST  = 32'h0000_0000;
   localparam logic        PHY_OWNER_RST = 1'b1;
   localparam logic        IMG_RST       = 1'b0;
   localparam logic        SWAP_RST      = 1'b0;
   localparam logic        LATE_RST      = 1'b0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // ack codes given by the responder
   localparam logic [3:0]  ACK_COMPLETE  = 4'h1;
   localparam logic [3:0]  ACK_PENDING   = 4'h2;
   localparam logic [3:0]  ACK_TARDY     = 4'hb;
   localparam logic [3:0]  ACK_TYPE_ERR  = 4'he;
endpackage

// ==== hdl/olc_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - record requester bus and node number
// - record upper destination offset bits
// - error source read-only, updated on failure
// - fixed read-only maker identity register
// - set and clear addresses update flags
// - image ready enables config ROM responses
// - image not ready gives type error to ROM block reads
// - image not ready blocks ROM register refresh
// - image cleared by soft reset, aresetn or fetch error
// - swap disable flag steers DMA swapping
// - late ack permit makes tardy answers
// - tardy answer raises interrupt event bit
// - bits 28 to 24 read zero
// - phy owner read-only, default one, EEPROM
// - phy owner reset to one only by global reset
module olc_regs (
   // clock and resets
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        global_reset_n,
   input  wire logic        soft_reset,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // link side events
   input  wire logic        link_active,
   input  wire logic        pw_fail,
   input  wire logic [9:0]  pw_fail_bus,
   input  wire logic [5:0]  pw_fail_node,
   input  wire logic [47:0] pw_fail_offset,
   input  wire logic        bib_fetch_err,
   input  wire logic        eeprom_load,
   input  wire logic        eeprom_phy_owner,
   input  wire logic        rx_req,
   input  wire logic        rx_rom_block_rd,
   input  wire logic        bus_reset,
   // responder and datapath controls
   output logic [31:0]      fail_offset_lo,
   output logic             rom_resp_en,
   output logic             rom_regs_update,
   output logic [3:0]       ack_code,
   output logic             ack_valid,
   output logic             tardy_event,
   output logic             byte_swap_en,
   output logic             phy_owner
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] src_q, src_d, lo_q, lo_d;
   logic        img_q, img_d, swap_q, swap_d, late_q, late_d, own_q, own_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0]  ws_q, ws_d;
   logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d;
   logic [1:0]  br_q, br_d;
   logic        rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0]  rr_q, rr_d;
   logic [3:0]  ack_q, ack_d;
   logic        av_q, av_d, te_q, te_d, rru_q, rru_d;

   // byte-lane merge: a cleared strobe leaves its byte out of the update
   function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] s);
      lanes = {{8{s[3]}} & d[31:24], {8{s[2]}} & d[23:16], {8{s[1]}} & d[15:8], {8{s[0]}} & d[7:0]};
   endfunction

   // read image of the control pair, reserved bits forced to zero
   function automatic logic [31:0] ctrl_img(input logic i, input logic s, input logic l, input logic o);
      ctrl_img = 32'h0000_0000;
      ctrl_img[olc_pkg::BIT_IMG_READY] = i;
      ctrl_img[olc_pkg::BIT_SWAP_DIS]  = s;
      ctrl_img[olc_pkg::BIT_LATE_ACK]  = l;
      ctrl_img[olc_pkg::BIT_PHY_OWNER] = o; // bits 28..24 stay zero
   endfunction

   logic        wr_go;
   logic [31:0] wm;
   assign wr_go = awh_q && wh_q && !bv_q;
   assign wm    = lanes(wd_q, ws_q);

   // ------------------------------------------------------------
   // bus slave and register next state
   // ------------------------------------------------------------
   always_comb begin
      awa_d = awa_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      awh_d = awh_q;
      wh_d  = wh_q;
      bv_d  = bv_q;
      br_d  = br_q;
      rv_d  = rv_q;
      rd_d  = rd_q;
      rr_d  = rr_q;
      src_d = src_q;
      lo_d  = lo_q;
      img_d = img_q;
      swap_d = swap_q;
      late_d = late_q;
      own_d  = own_q;
      // address and data are latched separately, in either order
      if (s_awvalid && !awh_q) begin
         awa_d = s_awaddr;
         awh_d = 1'b1;
      end
      if (s_wvalid && !wh_q) begin
         wd_d = s_wdata;
         ws_d = s_wstrb;
         wh_d = 1'b1;
      end
      if (wr_go) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = olc_pkg::RESP_OKAY;
         case (awa_q & 8'hfc)
            olc_pkg::OFF_CTRL_SET: begin
               // image ready is only taken while the link is inactive
               if (wm[olc_pkg::BIT_IMG_READY] && !link_active) begin
                  img_d = 1'b1;
               end
               if (wm[olc_pkg::BIT_SWAP_DIS]) begin
                  swap_d = 1'b1;
               end
               if (wm[olc_pkg::BIT_LATE_ACK]) begin
                  late_d = 1'b1;
               end
            end
            olc_pkg::OFF_CTRL_CLR: begin
               if (wm[olc_pkg::BIT_SWAP_DIS]) begin
                  swap_d = 1'b0;
               end
               if (wm[olc_pkg::BIT_LATE_ACK]) begin
                  late_d = 1'b0;
               end
            end
            olc_pkg::OFF_FAIL_SRC, olc_pkg::OFF_MAKER_ID: begin
               // read-only: write accepted and dropped
            end
            default: begin
               br_d = olc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (bv_q && s_bready) begin
         bv_d = 1'b0;
      end
      // read path
      if (s_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = olc_pkg::RESP_OKAY;
         case (s_araddr & 8'hfc)
            olc_pkg::OFF_FAIL_SRC: rd_d = src_q;
            olc_pkg::OFF_MAKER_ID: rd_d = olc_pkg::MAKER_ID_VAL;
            olc_pkg::OFF_CTRL_SET, olc_pkg::OFF_CTRL_CLR: begin
               rd_d = ctrl_img(img_q, swap_q, late_q, own_q);
            end
            default: begin
               rd_d = 32'h0000_0000;
               rr_d = olc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_rready) begin
         rv_d = 1'b0;
      end
      // both halves of the failing address come from one event
      if (pw_fail) begin
         src_d = {pw_fail_bus, pw_fail_node, pw_fail_offset[47:32]};
         lo_d  = pw_fail_offset[31:0];
      end
      // resets and fetch errors beat a concurrent set
      if (soft_reset || bib_fetch_err) begin
         img_d = olc_pkg::IMG_RST;
      end
      if (soft_reset) begin
         swap_d = olc_pkg::SWAP_RST;
         late_d = olc_pkg::LATE_RST;
      end
      // owner flag ignores soft reset, only the eeprom load changes it
      if (eeprom_load) begin
         own_d = eeprom_phy_owner;
      end
   end

   // ------------------------------------------------------------
   // responder next state
   // ------------------------------------------------------------
   always_comb begin
      ack_d = ack_q;
      av_d  = 1'b0;
      te_d  = 1'b0;
      rru_d = 1'b0;
      if (rx_req) begin
         av_d = 1'b1;
         if (rx_rom_block_rd && !img_q) begin
            ack_d = olc_pkg::ACK_TYPE_ERR;
         end else if (late_q) begin
            ack_d = olc_pkg::ACK_TARDY;
            te_d  = 1'b1;
         end else if (rx_rom_block_rd) begin
            ack_d = olc_pkg::ACK_COMPLETE;
         end else begin
            ack_d = olc_pkg::ACK_PENDING;
         end
      end
      // rom mapping, header and bus options refresh only with image ready
      if (bus_reset && img_q) begin
         rru_d = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awa_q <= 8'h00;
         wd_q  <= 32'h0000_0000;
         ws_q  <= 4'h0;
         awh_q <= 1'b0;
         wh_q  <= 1'b0;
         bv_q  <= 1'b0;
         br_q  <= olc_pkg::RESP_OKAY;
         rv_q  <= 1'b0;
         rd_q  <= 32'h0000_0000;
         rr_q  <= olc_pkg::RESP_OKAY;
         src_q <= olc_pkg::FAIL_SRC_RST;
         lo_q  <= olc_pkg::FAIL_SRC_RST;
         img_q <= olc_pkg::IMG_RST;
         swap_q <= olc_pkg::SWAP_RST;
         late_q <= olc_pkg::LATE_RST;
         ack_q <= 4'h0;
         av_q  <= 1'b0;
         te_q  <= 1'b0;
         rru_q <= 1'b0;
      end else begin
         awa_q <= awa_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         awh_q <= awh_d;
         wh_q  <= wh_d;
         bv_q  <= bv_d;
         br_q  <= br_d;
         rv_q  <= rv_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
         src_q <= src_d;
         lo_q  <= lo_d;
         img_q <= img_d;
         swap_q <= swap_d;
         late_q <= late_d;
         ack_q <= ack_d;
         av_q  <= av_d;
         te_q  <= te_d;
         rru_q <= rru_d;
      end
   end

   // owner flag lives on the global reset only, so a soft or bus reset keeps it
   always_ff @(posedge aclk) begin
      if (!global_reset_n) begin
         own_q <= olc_pkg::PHY_OWNER_RST;
      end else begin
         own_q <= own_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_awready       = !awh_q;
   assign s_wready        = !wh_q;
   assign s_bvalid        = bv_q;
   assign s_bresp         = br_q;
   assign s_arready       = !rv_q;
   assign s_rvalid        = rv_q;
   assign s_rdata         = rd_q;
   assign s_rresp         = rr_q;
   assign fail_offset_lo  = lo_q;
   assign rom_resp_en     = img_q;
   assign rom_regs_update = rru_q;
   assign ack_code        = ack_q;
   assign ack_valid       = av_q;
   assign tardy_event     = te_q;
   assign byte_swap_en    = !swap_q;
   assign phy_owner       = own_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_tardy_req;
      rx_req && late_q && !(rx_rom_block_rd && !img_q);
   endsequence

   AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
      pw_fail |=> src_q[31:22] == $past(pw_fail_bus) && src_q[21:16] == $past(pw_fail_node))
      else $error("source node not captured");
   AST_OFFSET_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
      pw_fail |=> {src_q[15:0], lo_q} == $past(pw_fail_offset))
      else $error("offset halves differ");
   AST_SRC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      !pw_fail |=> $stable(src_q))
      else $error("error source changed without failure");
   AST_MAKER: assert property (@(posedge aclk) disable iff (!aresetn)
      s_arvalid && s_arready && (s_araddr & 8'hfc) == olc_pkg::OFF_MAKER_ID |=> s_rdata == olc_pkg::MAKER_ID_VAL)
      else $error("maker identity wrong");
   AST_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rvalid && s_rdata != olc_pkg::MAKER_ID_VAL && s_rdata != src_q |-> s_rdata[28:24] == 5'h00)
      else $error("reserved control bits nonzero");
   AST_TYPE_ERR: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_req && rx_rom_block_rd && !img_q |=> ack_valid && ack_code == olc_pkg::ACK_TYPE_ERR)
      else $error("rom read without image not refused");
   AST_TARDY: assert property (@(posedge aclk) disable iff (!aresetn)
      s_tardy_req |=> ack_code == olc_pkg::ACK_TARDY ##0 tardy_event ##1 !tardy_event || $past(rx_req))
      else $error("tardy answer or event missing");
   AST_ROM_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_reset && !img_q |=> !rom_regs_update)
      else $error("rom registers refreshed without image");
   AST_IMG_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      soft_reset || bib_fetch_err |=> !rom_resp_en)
      else $error("image ready survived reset");
   AST_OWNER: assert property (@(posedge aclk) disable iff (!global_reset_n)
      global_reset_n && !eeprom_load |=> $stable(phy_owner))
      else $error("owner flag changed without load");
endmodule

// ==== dv/olc_node_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// remote node model: requests, bus resets and failed writes
// ------------------------------------------------------------
module olc_node_model (
   // clock
   input  wire logic        aclk,
   // pulses and fields toward the link
   output logic             rx_req,
   output logic             rx_rom_block_rd,
   output logic             bus_reset,
   output logic             pw_fail,
   output logic [9:0]       pw_fail_bus,
   output logic [5:0]       pw_fail_node,
   output logic [47:0]      pw_fail_offset
);
   // idle lines; fields carry junk so a stale value never looks valid
   initial begin
      rx_req          = 1'b0;
      rx_rom_block_rd = 1'b0;
      bus_reset       = 1'b0;
      pw_fail         = 1'b0;
      pw_fail_bus     = 10'h3ff;
      pw_fail_node    = 6'h3f;
      pw_fail_offset  = 48'hffff_ffff_ffff;
   end
   // one-cycle request, qualifier inverted once the request is gone
   task automatic request(input logic rom);
      @(posedge aclk);
      rx_req          <= 1'b1;
      rx_rom_block_rd <= rom;
      @(posedge aclk);
      rx_req          <= 1'b0;
      rx_rom_block_rd <= ~rom;
   endtask
   // one-cycle bus reset
   task automatic reset_bus();
      @(posedge aclk);
      bus_reset <= 1'b1;
      @(posedge aclk);
      bus_reset <= 1'b0;
   endtask
   // failed posted write; fields scrambled after the pulse
   task automatic fail(input logic [9:0] b, input logic [5:0] n, input logic [47:0] o);
      @(posedge aclk);
      pw_fail        <= 1'b1;
      pw_fail_bus    <= b;
      pw_fail_node   <= n;
      pw_fail_offset <= o;
      @(posedge aclk);
      pw_fail        <= 1'b0;
      pw_fail_bus    <= ~b;
      pw_fail_node   <= ~n;
      pw_fail_offset <= ~o;
   endtask
endmodule

// ==== dv/test_ohci_link_ctrl_error_regs.sv ====
`timescale 1ns/1ps
module test_ohci_link_ctrl_error_regs;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        aclk, aresetn, global_reset_n, soft_reset, link_active;
   logic        bib_fetch_err, eeprom_load, eeprom_phy_owner;
   logic [7:0]  s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, fail_offset_lo, rv;
   logic [3:0]  s_wstrb, ack_code;
   logic [1:0]  s_bresp, s_rresp, rp;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic        s_arvalid, s_arready, s_rvalid, s_rready;
   logic        rx_req, rx_rom_block_rd, bus_reset, pw_fail;
   logic [9:0]  pw_fail_bus;
   logic [5:0]  pw_fail_node;
   logic [47:0] pw_fail_offset;
   logic        rom_resp_en, rom_regs_update, ack_valid, tardy_event, byte_swap_en, phy_owner;
   int          mismatches, tests_run;
   localparam logic [1:0] OK = olc_pkg::RESP_OKAY;
   localparam logic [1:0] ER = olc_pkg::RESP_SLVERR;
   typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r; } olc_row_t;
   // ordinary register traffic: write rows check bresp, read rows rdata and rresp
   olc_row_t rows [13] = '{
      '{1'b0, 8'h40, 32'h0, olc_pkg::MAKER_ID_VAL, OK}, '{1'b1, 8'h40, 32'hffff_ffff, 32'h0, OK},
      '{1'b0, 8'h40, 32'h0, olc_pkg::MAKER_ID_VAL, OK}, '{1'b0, 8'h50, 32'h0, 32'h0080_0000, OK},
      '{1'b0, 8'h3c, 32'h0, olc_pkg::FAIL_SRC_RST, OK}, '{1'b1, 8'h3c, 32'hffff_ffff, 32'h0, OK},
      '{1'b0, 8'h3c, 32'h0, olc_pkg::FAIL_SRC_RST, OK}, '{1'b1, 8'h50, 32'hffff_ffff, 32'h0, OK},
      '{1'b0, 8'h54, 32'h0, 32'he080_0000, OK}, '{1'b1, 8'h54, 32'hffff_ffff, 32'h0, OK},
      '{1'b0, 8'h50, 32'h0, 32'h8080_0000, OK}, '{1'b0, 8'h60, 32'h0, 32'h0, ER},
      '{1'b1, 8'h60, 32'h1, 32'h0, ER}};
   // ------------------------------------------------------------
   // design and far-side model
   // ------------------------------------------------------------
   olc_regs u_dut (.aclk, .aresetn, .global_reset_n, .soft_reset, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .link_active, .pw_fail, .pw_fail_bus,
      .pw_fail_node, .pw_fail_offset, .bib_fetch_err, .eeprom_load, .eeprom_phy_owner, .rx_req,
      .rx_rom_block_rd, .bus_reset, .fail_offset_lo, .rom_resp_en, .rom_regs_update, .ack_code,
      .ack_valid, .tardy_event, .byte_swap_en, .phy_owner);
   olc_node_model u_node (.aclk, .rx_req, .rx_rom_block_rd, .bus_reset, .pw_fail, .pw_fail_bus,
      .pw_fail_node, .pw_fail_offset);
   // 100 ns clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // a hung handshake ends the run instead of stalling it
   task automatic hung();
      mismatches++;
      $display("MISMATCH handshake expected answer seen none");
      summarize();
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic pa, pw;
      @(posedge aclk);
      s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wvalid <= 1'b1; s_bready <= 1'b1;
      pa = 1'b1; pw = 1'b1; n = 0;
      forever begin
         @(posedge aclk);
         if (pa && s_awready) begin pa = 1'b0; s_awvalid <= 1'b0; end
         if (pw && s_wready) begin pw = 1'b0; s_wvalid <= 1'b0; end
         if (s_bvalid) begin rp = s_bresp; s_bready <= 1'b0; break; end
         if (++n > 40) hung();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      logic pa;
      @(posedge aclk);
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      pa = 1'b1; n = 0;
      forever begin
         @(posedge aclk);
         if (pa && s_arready) begin pa = 1'b0; s_arvalid <= 1'b0; end
         if (s_rvalid) begin rv = s_rdata; rp = s_rresp; s_rready <= 1'b0; break; end
         if (++n > 40) hung();
      end
   endtask
   // one request from the far node, answer looked at in its single cycle
   task automatic ack(input logic rom, input logic [3:0] e, input logic t);
      u_node.request(rom);
      #1;
      chk("ack_valid", 32'(ack_valid), 32'h1);
      chk("ack_code", 32'(ack_code), 32'(e));
      chk("tardy_event", 32'(tardy_event), 32'(t));
   endtask
   task automatic busrst(input logic e);
      u_node.reset_bus();
      #1;
      chk("rom_regs_update", 32'(rom_regs_update), 32'(e));
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      mismatches = 0; tests_run = 0; aresetn = 1'b0; global_reset_n = 1'b0; soft_reset = 1'b0;
      link_active = 1'b0; bib_fetch_err = 1'b0; eeprom_load = 1'b0; eeprom_phy_owner = 1'b1;
      s_awaddr = 8'h0; s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'hf; s_wvalid = 1'b0;
      s_bready = 1'b0; s_araddr = 8'h0; s_arvalid = 1'b0; s_rready = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1; global_reset_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a);
         if (!rows[i].wr) chk("rdata", rv, rows[i].x);
         chk("resp", 32'(rp), 32'(rows[i].r));
      end
      chk("byte_swap_en", 32'(byte_swap_en), 32'h1);
      wr(8'h50, 32'h4000_0000);
      chk("byte_swap_en", 32'(byte_swap_en), 32'h0);
      wr(8'h54, 32'h4000_0000);
      chk("byte_swap_en", 32'(byte_swap_en), 32'h1);
      // top byte lane masked off, so the swap disable set must not land
      s_wstrb <= 4'h7;
      wr(8'h50, 32'h4000_0000);
      chk("byte_swap_en", 32'(byte_swap_en), 32'h1);
      s_wstrb <= 4'hf;
      ack(1'b1, olc_pkg::ACK_COMPLETE, 1'b0);
      busrst(1'b1);
      wr(8'h50, 32'h2000_0000); // late ack permit set, so tardy answers follow
      ack(1'b0, olc_pkg::ACK_TARDY, 1'b1);
      wr(8'h54, 32'h2000_0000);
      ack(1'b0, olc_pkg::ACK_PENDING, 1'b0); // tardy event left clear, late ack permit cleared by the write to 8'h54
      u_node.fail(10'h2a5, 6'h1b, 48'hbeef_1234_5678);
      #1;
      chk("fail_offset_lo", fail_offset_lo, 32'h1234_5678);
      rd(8'h3c);
      chk("fail_source", rv, {10'h2a5, 6'h1b, 16'hbeef});
      @(posedge aclk); bib_fetch_err <= 1'b1;
      @(posedge aclk); bib_fetch_err <= 1'b0;
      @(posedge aclk); #1;
      chk("rom_resp_en", 32'(rom_resp_en), 32'h0);
      ack(1'b1, olc_pkg::ACK_TYPE_ERR, 1'b0);
      busrst(1'b0);
      @(posedge aclk); link_active <= 1'b1;
      wr(8'h50, 32'h8000_0000); // set refused while the link is active
      chk("rom_resp_en", 32'(rom_resp_en), 32'h0);
      link_active <= 1'b0;
      wr(8'h50, 32'h8000_0000); // image built, link inactive
      chk("rom_resp_en", 32'(rom_resp_en), 32'h1);
      @(posedge aclk); soft_reset <= 1'b1;
      @(posedge aclk); soft_reset <= 1'b0;
      @(posedge aclk); #1;
      chk("rom_resp_en", 32'(rom_resp_en), 32'h0);
      @(posedge aclk); eeprom_phy_owner <= 1'b0; eeprom_load <= 1'b1;
      @(posedge aclk); eeprom_load <= 1'b0; eeprom_phy_owner <= 1'b1;
      @(posedge aclk); soft_reset <= 1'b1;
      @(posedge aclk); soft_reset <= 1'b0;
      @(posedge aclk); #1;
      chk("phy_owner", 32'(phy_owner), 32'h0);
      wr(8'h50, 32'h0080_0000);
      rd(8'h50);
      chk("ctrl_flags", rv, 32'h0000_0000);
      @(posedge aclk); global_reset_n <= 1'b0;
      @(posedge aclk); global_reset_n <= 1'b1;
      @(posedge aclk); #1;
      chk("phy_owner", 32'(phy_owner), 32'h1);
      wr(8'h50, 32'h6000_0000);
      @(posedge aclk); aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h50);
      chk("ctrl_flags", rv, 32'h0080_0000);
      summarize();
   end
endmodule
